// file: design/axil_front.sv
// axi4-lite slave handshakes: address/data capture and answers
`timescale 1ns/1ps
module axil_front
(
  // clock and reset
  input  logic                       clk_sys,
  input  logic                       rst_b,
  // bus
  input  sgdma_pkg::axil_req_t       s_req,
  output sgdma_pkg::axil_rsp_t       s_rsp,
  // register file side
  input  logic [31:0]                rd_word,
  input  logic                       rd_err,
  input  logic                       wr_err,
  output logic                       wr_en,
  output logic [sgdma_pkg::AXI_AW-1:0] wr_addr,
  output logic [31:0]                wr_data,
  output logic [3:0]                 wr_strb
);
  import sgdma_pkg::*;

  typedef struct packed {
    logic              aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    axil_rsp_t         rsp;
  } front_t;

  front_t r;
  front_t n;

  // write fires once address and data are both held
  assign wr_en   = r.aw_held & r.w_held & ~r.rsp.bvalid;
  assign wr_addr = r.aw_addr;
  assign wr_data = r.w_data;
  assign wr_strb = r.w_strb;

  // channels taken in either order; read answered at the taking edge
  always_comb
  begin
    n = r;
    if (s_req.awvalid && r.rsp.awready)
    begin
      n.aw_held = 1'b1;
      n.aw_addr = s_req.awaddr;
    end
    if (s_req.wvalid && r.rsp.wready)
    begin
      n.w_held = 1'b1;
      n.w_data = s_req.wdata;
      n.w_strb = s_req.wstrb;
    end
    if (r.rsp.bvalid && s_req.bready)
      n.rsp.bvalid = 1'b0;
    if (wr_en)
    begin
      n.aw_held    = 1'b0;
      n.w_held     = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_req.arvalid && r.rsp.arready)
    begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata  = rd_word;
      n.rsp.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (r.rsp.rvalid && s_req.rready)
      n.rsp.rvalid = 1'b0;
    n.rsp.awready = ~n.aw_held & ~n.rsp.bvalid;
    n.rsp.wready  = ~n.w_held & ~n.rsp.bvalid;
    n.rsp.arready = ~n.rsp.rvalid;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else
      r <= n;
  end

  assign s_rsp = r.rsp;
endmodule : axil_front

// file: design/sgdma_ctrl.sv
// scatter-gather dma control: registers, descriptor walk, byte counting
//
// Function
// - start loads chain byte count into counter
// - each transfer decreases the remaining count
// - at zero reload count, fetch first descriptor
// - remaining count readable as two words
// - auto-start restarts at zero, else stops
// - abort stops at once, reads zero
// - direction: 0 writes host, 1 reads
// - unthrottled mode ignores acquisition data availability
// - width bit picks 32 or 64-bit beats
// - chaining bit picks single or chained operation
// - new first pointer used only at start and at zero
// - descriptor gives destination, size, next address
`timescale 1ns/1ps
module sgdma_ctrl
(
  // clock and reset
  input  logic                  clk_sys,
  input  logic                  rst_b,
  // register bus
  input  sgdma_pkg::axil_req_t  s_req,
  output sgdma_pkg::axil_rsp_t  s_rsp,
  // host memory port
  output sgdma_pkg::host_req_t  hm_out,
  input  logic                  hm_ack,
  input  logic [63:0]           hm_rdata,
  // acquisition source
  input  logic                  acq_valid,
  input  logic [63:0]           acq_data,
  output logic                  acq_take,
  // data read from host
  output logic                  snk_valid,
  output logic [63:0]           snk_data
);
  import sgdma_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic                 wr_en;
  logic [AXI_AW-1:0]    wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic [31:0]          rd_word;
  logic                 rd_err;
  logic                 wr_err;
  logic [31:0]          ptr_lo;
  logic [31:0]          ptr_hi;
  logic [31:0]          cnt_lo;
  logic [31:0]          cnt_hi;
  logic [31:0]          ctl;
  logic [63:0]          first_ptr;
  logic [63:0]          chain_cnt;
  logic                 abort_wr;
  logic                 go_wr;

  axil_front u_front
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .s_req   (s_req),
    .s_rsp   (s_rsp),
    .rd_word (rd_word),
    .rd_err  (rd_err),
    .wr_err  (wr_err),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb)
  );

  wstrb_word u_ptr_lo
  (
    .clk_sys (clk_sys), .rst_b (rst_b), .strb (wr_strb), .din (wr_data),
    .wr      (wr_en && wr_addr == OFS_FIRST_DESCRIPTOR_LO),
    .q       (ptr_lo)
  );

  wstrb_word u_ptr_hi
  (
    .clk_sys (clk_sys), .rst_b (rst_b), .strb (wr_strb), .din (wr_data),
    .wr      (wr_en && wr_addr == OFS_FIRST_DESCRIPTOR_HI),
    .q       (ptr_hi)
  );

  wstrb_word u_cnt_lo
  (
    .clk_sys (clk_sys), .rst_b (rst_b), .strb (wr_strb), .din (wr_data),
    .wr      (wr_en && wr_addr == OFS_CHAIN_BYTE_COUNT_LOW),
    .q       (cnt_lo)
  );

  wstrb_word u_cnt_hi
  (
    .clk_sys (clk_sys), .rst_b (rst_b), .strb (wr_strb), .din (wr_data),
    .wr      (wr_en && wr_addr == OFS_CHAIN_BYTE_COUNT_HIGH),
    .q       (cnt_hi)
  );

  // only documented control bits are kept; abort is never stored
  wstrb_word #(.MASK (CTL_KEEP_MASK)) u_ctl
  (
    .clk_sys (clk_sys), .rst_b (rst_b), .strb (wr_strb), .din (wr_data),
    .wr      (wr_en && wr_addr == OFS_TRANSFER_CONTROL),
    .q       (ctl)
  );

  assign first_ptr = {ptr_hi, ptr_lo};
  assign chain_cnt = {cnt_hi, cnt_lo};
  assign abort_wr  = wr_en && wr_addr == OFS_TRANSFER_CONTROL &&
                     wr_strb[0] && wr_data[CTL_ABORT];
  assign go_wr     = wr_en && wr_addr == OFS_DMA_START &&
                     wr_strb[0] && wr_data[START_BIT];
  assign wr_err    = (wr_addr[1:0] != 2'h0) ||
                     (wr_addr > OFS_DMA_START);

  // ----------------------------------------------------------------
  // engine state
  // ----------------------------------------------------------------
  typedef struct packed {
    eng_state_t  st;
    logic [1:0]  idx;
    logic [63:0] bytes_left;
    logic [63:0] desc_ptr;
    logic [63:0] xaddr;
    logic [31:0] dleft;
    logic [63:0] next_ptr;
    host_req_t   hm;
    logic        acq_take;
    logic        snk_valid;
    logic [63:0] snk_data;
  } eng_t;

  eng_t        r;
  eng_t        n;
  logic [63:0] beat;
  logic        start_evt;
  logic        zero_evt;
  logic        end_desc;
  logic        ack_x;

  assign beat      = ctl[CTL_WIDE] ? BEAT_BYTES_64 : BEAT_BYTES_32;
  assign ack_x     = r.st == ST_XFER && r.hm.req && hm_ack;
  assign zero_evt  = ack_x && r.bytes_left <= beat;
  // start needs the normal command code and a nonzero count
  assign start_evt = r.st == ST_IDLE && go_wr && chain_cnt != 64'h0 &&
                     ctl[CTL_CMD_LSB +: 4] == CMD_NORMAL;

  // descriptor walk and beat issue; one host request in flight
  always_comb
  begin
    n           = r;
    end_desc    = 1'b0;
    n.acq_take  = 1'b0;
    n.snk_valid = 1'b0;
    unique case (r.st)
      ST_IDLE:
      begin
        if (start_evt)
        begin
          n.bytes_left = chain_cnt;
          n.desc_ptr   = first_ptr;
          n.idx        = DESC_DEST;
          n.st         = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (!r.hm.req)
        begin
          n.hm.req  = 1'b1;
          n.hm.we   = 1'b0;
          n.hm.wide = 1'b1;
          n.hm.addr = r.desc_ptr + {59'h0, r.idx, 3'h0};
        end
        else if (hm_ack)
        begin
          n.hm.req = 1'b0;
          unique case (r.idx)
            DESC_DEST: n.xaddr    = hm_rdata;
            DESC_SIZE: n.dleft    = hm_rdata[31:0];
            DESC_NEXT: n.next_ptr = hm_rdata;
            default:   n.st       = ST_IDLE;
          endcase
          if (r.idx == DESC_NEXT)
            n.st = ST_XFER;
          else
            n.idx = r.idx + 2'h1;
        end
      end
      ST_XFER:
      begin
        if (!r.hm.req)
        begin
          if (r.dleft == 32'h0)
            end_desc = 1'b1;
          else if (ctl[CTL_DIRECTION])
          begin
            n.hm.req  = 1'b1;
            n.hm.we   = 1'b0;
            n.hm.wide = ctl[CTL_WIDE];
            n.hm.addr = r.xaddr;
          end
          else if (acq_valid || ctl[CTL_UNTHROTTLED])
          begin
            n.hm.req    = 1'b1;
            n.hm.we     = 1'b1;
            n.hm.wide   = ctl[CTL_WIDE];
            n.hm.addr   = r.xaddr;
            n.hm.wdata  = acq_data;
            n.acq_take  = acq_valid;
          end
        end
        else if (hm_ack)
        begin
          n.hm.req = 1'b0;
          n.xaddr  = r.xaddr + beat;
          n.dleft  = (r.dleft > beat[31:0]) ? r.dleft - beat[31:0] : 32'h0;
          if (!r.hm.we)
          begin
            n.snk_valid = 1'b1;
            n.snk_data  = hm_rdata;
          end
          if (!zero_evt)
          begin
            n.bytes_left = r.bytes_left - beat;
            end_desc     = n.dleft == 32'h0;
          end
          else
          begin
            n.bytes_left = chain_cnt;
            n.desc_ptr   = first_ptr;
            n.idx        = DESC_DEST;
            n.st         = ctl[CTL_AUTO_START] ? ST_FETCH : ST_IDLE;
          end
        end
        if (end_desc)
        begin
          n.desc_ptr = r.next_ptr;
          n.idx      = DESC_DEST;
          n.st       = ctl[CTL_CHAINING] ? ST_FETCH : ST_IDLE;
        end
      end
      default:
        n.st = ST_IDLE;
    endcase
    if (abort_wr)
    begin
      n.st     = ST_IDLE;
      n.hm.req = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r    <= '0;
      r.st <= ST_IDLE;
    end
    else
      r <= n;
  end

  assign hm_out    = r.hm;
  assign acq_take  = r.acq_take;
  assign snk_valid = r.snk_valid;
  assign snk_data  = r.snk_data;

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = REG_RESET;
    rd_err  = 1'b0;
    case (s_req.araddr)
      OFS_FIRST_DESCRIPTOR_LO:   rd_word = ptr_lo;
      OFS_FIRST_DESCRIPTOR_HI:   rd_word = ptr_hi;
      OFS_CHAIN_BYTE_COUNT_LOW:  rd_word = cnt_lo;
      OFS_CHAIN_BYTE_COUNT_HIGH: rd_word = cnt_hi;
      OFS_BYTES_REMAINING_LOW:   rd_word = r.bytes_left[31:0];
      OFS_BYTES_REMAINING_HIGH:  rd_word = r.bytes_left[63:32];
      OFS_TRANSFER_CONTROL:      rd_word = ctl;
      OFS_DMA_START:             rd_word = {31'h0, r.st != ST_IDLE};
      default:                   rd_err  = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_rd_at(logic [7:0] ofs);
    s_req.arvalid && s_rsp.arready && s_req.araddr == ofs;
  endsequence

  sequence s_fetch_last;
    r.st == ST_FETCH && r.hm.req && hm_ack && r.idx == DESC_NEXT;
  endsequence

  property p_start_load;
    start_evt && !abort_wr |=> r.bytes_left == $past(chain_cnt) &&
                               r.st == ST_FETCH ##1 r.hm.req;
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start did not load chain count");

  property p_count_down;
    ack_x && !zero_evt && !abort_wr |=>
      r.bytes_left == $past(r.bytes_left) - $past(beat);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("remaining count not decreased by beat");

  property p_reload;
    zero_evt && !abort_wr |=> r.bytes_left == $past(chain_cnt);
  endproperty
  a_reload: assert property (p_reload)
    else $error("count not reloaded at zero");

  property p_read_remaining;
    s_rd_at(OFS_BYTES_REMAINING_HIGH) |=>
      s_rsp.rvalid && s_rsp.rdata == $past(r.bytes_left[63:32]);
  endproperty
  a_read_remaining: assert property (p_read_remaining)
    else $error("remaining high word misread");

  property p_auto_restart;
    zero_evt && !abort_wr && ctl[CTL_AUTO_START] |=>
      r.st == ST_FETCH && r.desc_ptr == $past(first_ptr) ##1
      ($past(abort_wr) ||
       (r.hm.req && r.hm.addr == $past(first_ptr, 2)));
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto restart did not fetch first descriptor");

  property p_no_restart;
    zero_evt && !abort_wr && !ctl[CTL_AUTO_START] |=>
      r.st == ST_IDLE [*2];
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("engine restarted with auto-start off");

  property p_abort;
    abort_wr |=> r.st == ST_IDLE && !r.hm.req && !ctl[CTL_ABORT];
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not stop engine");

  property p_direction;
    $rose(r.hm.req) && r.st == ST_XFER |->
      r.hm.we == !$past(ctl[CTL_DIRECTION]);
  endproperty
  a_direction: assert property (p_direction)
    else $error("beat direction wrong");

  property p_throttle;
    r.st == ST_XFER && !r.hm.req && r.dleft != 32'h0 && !acq_valid &&
    !ctl[CTL_DIRECTION] && !ctl[CTL_UNTHROTTLED] |=> !r.hm.req;
  endproperty
  a_throttle: assert property (p_throttle)
    else $error("write beat issued without acquisition data");

  property p_width;
    ack_x && !zero_evt && !abort_wr |=>
      r.xaddr == $past(r.xaddr) + ($past(ctl[CTL_WIDE]) ?
                                   BEAT_BYTES_64 : BEAT_BYTES_32);
  endproperty
  a_width: assert property (p_width)
    else $error("address step does not match width");

  property p_desc_end;
    end_desc && !abort_wr |=>
      ($past(ctl[CTL_CHAINING]) && r.st == ST_FETCH &&
       r.desc_ptr == $past(r.next_ptr)) ||
      (!$past(ctl[CTL_CHAINING]) && r.st == ST_IDLE);
  endproperty
  a_desc_end: assert property (p_desc_end)
    else $error("descriptor end handled wrongly");

  property p_fetch_done;
    s_fetch_last ##0 !abort_wr |=>
      r.st == ST_XFER && r.next_ptr == $past(hm_rdata);
  endproperty
  a_fetch_done: assert property (p_fetch_done)
    else $error("descriptor fetch did not complete");

  property p_reserved_zero;
    s_rd_at(OFS_TRANSFER_CONTROL) |=>
      (s_rsp.rdata & ~CTL_KEEP_MASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits not zero");

endmodule : sgdma_ctrl

// file: design/sgdma_pkg.sv
// shared constants, carriers and states of the scatter-gather dma control
package sgdma_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW                      = 8;
  localparam logic [7:0]  OFS_FIRST_DESCRIPTOR_LO     = 8'h00;
  localparam logic [7:0]  OFS_FIRST_DESCRIPTOR_HI     = 8'h04;
  localparam logic [7:0]  OFS_CHAIN_BYTE_COUNT_LOW    = 8'h08;
  localparam logic [7:0]  OFS_CHAIN_BYTE_COUNT_HIGH   = 8'h0c;
  localparam logic [7:0]  OFS_BYTES_REMAINING_LOW     = 8'h10;
  localparam logic [7:0]  OFS_BYTES_REMAINING_HIGH    = 8'h14;
  localparam logic [7:0]  OFS_TRANSFER_CONTROL        = 8'h18;
  localparam logic [7:0]  OFS_DMA_START               = 8'h1c;

  // ----------------------------------------------------------------
  // transfer_control fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTL_AUTO_START   = 0;
  localparam int unsigned CTL_ABORT        = 1;
  localparam int unsigned CTL_DIRECTION    = 2;
  localparam int unsigned CTL_UNTHROTTLED  = 8;
  localparam int unsigned CTL_WIDE         = 18;
  localparam int unsigned CTL_CHAINING     = 19;
  localparam int unsigned CTL_CMD_LSB      = 20;
  localparam logic [3:0]  CMD_NORMAL       = 4'hf;
  localparam logic [31:0] CTL_KEEP_MASK    = 32'h00fc0105;
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;
  localparam int unsigned START_BIT        = 0;

  // ----------------------------------------------------------------
  // bus answers, descriptor words and beat sizes
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam logic [1:0]  DESC_DEST        = 2'h0;
  localparam logic [1:0]  DESC_SIZE        = 2'h1;
  localparam logic [1:0]  DESC_NEXT        = 2'h2;
  localparam logic [63:0] BEAT_BYTES_32    = 64'h4;
  localparam logic [63:0] BEAT_BYTES_64    = 64'h8;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_XFER  = 3'b100
  } eng_state_t;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [63:0] addr;
    logic [63:0] wdata;
  } host_req_t;

endpackage : sgdma_pkg

// file: design/wstrb_word.sv
// one software register word with byte strobes and a keep mask
`timescale 1ns/1ps
module wstrb_word
#(
  parameter int unsigned W    = 32,
  parameter logic [W-1:0] MASK = '1
)
(
  // clock and reset
  input  logic             clk_sys,
  input  logic             rst_b,
  // write port
  input  logic             wr,
  input  logic [W/8-1:0]   strb,
  input  logic [W-1:0]     din,
  // stored value
  output logic [W-1:0]     q
);
  typedef struct packed {
    logic [W-1:0] q;
  } word_t;

  word_t r;
  word_t n;

  // byte lanes update only where strobed; masked bits stay zero
  always_comb
  begin
    n = r;
    if (wr)
    begin
      for (int b = 0; b < W/8; b++)
      begin
        if (strb[b])
          n.q[8*b +: 8] = din[8*b +: 8] & MASK[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else
      r <= n;
  end

  assign q = r.q;
endmodule : wstrb_word

// file: testbench/host_mem.sv
// host memory model that answers the dma engine's requests
`timescale 1ns/1ps
module host_mem
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // engine side
  input  wire sgdma_pkg::host_req_t hm_out,
  output logic                      hm_ack,
  output logic [63:0]               hm_rdata,
  // bench side
  input  wire logic [3:0]           lag,
  output int                        wr_cnt,
  output logic [63:0]               last_addr
);
  import sgdma_pkg::*;
  // ----------------------------------------------------------------
  // storage and answer timing
  // ----------------------------------------------------------------
  logic [63:0] mem [0:63];
  int          wait_cnt;

  // ack each held request after lag idle cycles; idle data keeps moving
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hm_ack <= 1'b0;
      hm_rdata <= 64'h0;
      wait_cnt <= 0;
      wr_cnt <= 0;
      last_addr <= 64'h0;
    end
    else
    begin
      hm_ack <= 1'b0;
      hm_rdata <= ~hm_rdata;
      if (!hm_out.req)
        wait_cnt <= 0;
      else if (!hm_ack && wait_cnt < lag)
        wait_cnt <= wait_cnt + 1;
      else if (!hm_ack)
      begin
        hm_ack <= 1'b1;
        wait_cnt <= 0;
        last_addr <= hm_out.addr;
        if (hm_out.we)
        begin
          mem[hm_out.addr[8:3]] <= hm_out.wdata;
          wr_cnt <= wr_cnt + 1;
        end
        else
          hm_rdata <= mem[hm_out.addr[8:3]];
      end
    end
  end
endmodule : host_mem

// file: testbench/sgdma_ctrl_tb.sv
// self-checking bench of the scatter-gather dma control
`timescale 1ns/1ps
module sgdma_ctrl_tb;
  import sgdma_pkg::*;
  localparam logic [31:0] CMD = 32'h00f0_0000;
  logic        clk_sys;
  logic        rst_b;
  axil_req_t   s_req;
  axil_rsp_t   s_rsp;
  host_req_t   hm_out;
  logic        hm_ack;
  logic [63:0] hm_rdata;
  logic        acq_valid;
  logic        acq_take;
  logic        snk_valid;
  logic [63:0] snk_data;
  logic [3:0]  lag;
  int          wr_cnt;
  logic [63:0] last_addr;
  logic [31:0] rd_data;
  logic [1:0]  rsp;
  int          err_total;
  int          check_count;
  int          snk_cnt;
  int          take_cnt;
  int          n0;

  sgdma_ctrl sgdma_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .s_req(s_req), .s_rsp(s_rsp), .hm_out(hm_out), .hm_ack(hm_ack),
    .hm_rdata(hm_rdata), .acq_valid(acq_valid),
    .acq_data(64'h5a5a_0f0f_a5a5_f0f0), .acq_take(acq_take),
    .snk_valid(snk_valid), .snk_data(snk_data));
  host_mem host_mem_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .hm_out(hm_out), .hm_ack(hm_ack), .hm_rdata(hm_rdata), .lag(lag),
    .wr_cnt(wr_cnt), .last_addr(last_addr));

  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // counts sink words and acquisition takes
  always @(posedge clk_sys)
  begin
    if (snk_valid === 1'b1) snk_cnt++;
    if (acq_take === 1'b1) take_cnt++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic fail;
    err_total++;
    results();
  endtask : fail

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_req.awaddr <= a;
    s_req.wdata <= d;
    s_req.wstrb <= 4'hf;
    s_req.awvalid <= 1'b1;
    s_req.wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_rsp.awready) s_req.awvalid <= 1'b0;
      if (s_rsp.wready) s_req.wvalid <= 1'b0;
    end
    while (s_rsp.bvalid !== 1'b1 && n < 60);
    rsp = s_rsp.bresp;
    if (n >= 60) fail();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_req.araddr <= a;
    s_req.arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_rsp.arready) s_req.arvalid <= 1'b0;
    end
    while (s_rsp.rvalid !== 1'b1 && n < 60);
    rd_data = s_rsp.rdata;
    rsp = s_rsp.rresp;
    if (n >= 60) fail();
  endtask : rd

  task automatic idle;
    int n;
    n = 0;
    do
    begin
      rd(OFS_DMA_START);
      n++;
    end
    while (rd_data[START_BIT] !== 1'b0 && n < 100);
    if (n >= 100) fail();
  endtask : idle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regs_check;
    rd(OFS_TRANSFER_CONTROL);
    chk(rd_data, REG_RESET);
    rd(OFS_BYTES_REMAINING_HIGH);
    chk(rd_data, REG_RESET);
    rd(8'h20);
    chk(rsp, RESP_SLVERR);
    wr(OFS_TRANSFER_CONTROL, 32'hffff_ffff);
    rd(OFS_TRANSFER_CONTROL);
    chk(rd_data, CTL_KEEP_MASK);
    wr(OFS_BYTES_REMAINING_LOW, 32'hffff_ffff);
    chk(rsp, RESP_OKAY);
    rd(OFS_BYTES_REMAINING_LOW);
    chk(rd_data, REG_RESET);
  endtask : regs_check

  task automatic write_run;
    host_mem_inst.mem[32] = 64'h80;
    host_mem_inst.mem[33] = 64'h10;
    host_mem_inst.mem[34] = 64'h180;
    wr(OFS_FIRST_DESCRIPTOR_LO, 32'h100);
    wr(OFS_FIRST_DESCRIPTOR_HI, 32'h0);
    wr(OFS_CHAIN_BYTE_COUNT_LOW, 32'h10);
    wr(OFS_CHAIN_BYTE_COUNT_HIGH, 32'h0);
    wr(OFS_TRANSFER_CONTROL, CMD);
    wr(OFS_DMA_START, 32'h1);
    repeat (30) @(posedge clk_sys);
    chk(wr_cnt, 0);
    acq_valid <= 1'b1;
    idle();
    chk(wr_cnt, 4);
    chk(last_addr, 64'h8c);
    chk(take_cnt, 4);
    chk(hm_out.wide, 1'b0);
    chk(host_mem_inst.mem[17], 64'h5a5a_0f0f_a5a5_f0f0);
    rd(OFS_BYTES_REMAINING_LOW);
    chk(rd_data, 32'h10);
  endtask : write_run

  task automatic chain_read;
    host_mem_inst.mem[16] = 64'h1111_2222_3333_4444;
    host_mem_inst.mem[24] = 64'h5555_6666_7777_8888;
    host_mem_inst.mem[33] = 64'h8;
    host_mem_inst.mem[48] = 64'hc0;
    host_mem_inst.mem[49] = 64'h8;
    host_mem_inst.mem[50] = 64'h100;
    lag <= 4'h3;
    n0 = snk_cnt;
    wr(OFS_TRANSFER_CONTROL, CMD | 32'h000c_0004);
    wr(OFS_DMA_START, 32'h1);
    idle();
    chk(snk_cnt - n0, 2);
    chk(snk_data, 64'h5555_6666_7777_8888);
    chk(wr_cnt, 4);
    chk(last_addr, 64'hc0);
    chk(hm_out.wide, 1'b1);
  endtask : chain_read

  task automatic auto_abort;
    lag <= 4'h0;
    acq_valid <= 1'b0;
    wr(OFS_CHAIN_BYTE_COUNT_LOW, 32'h8);
    wr(OFS_TRANSFER_CONTROL, CMD | 32'h0000_0101);
    n0 = wr_cnt;
    wr(OFS_DMA_START, 32'h1);
    repeat (100) @(posedge clk_sys);
    chk((wr_cnt - n0) > 4, 1'b1);
    chk(take_cnt, 4);
    wr(OFS_TRANSFER_CONTROL, CMD | 32'h2);
    rd(OFS_DMA_START);
    chk(rd_data[START_BIT], 1'b0);
    n0 = wr_cnt;
    repeat (20) @(posedge clk_sys);
    chk(wr_cnt, n0);
    wr(OFS_TRANSFER_CONTROL, 32'h0);
    wr(OFS_DMA_START, 32'h1);
    rd(OFS_DMA_START);
    chk(rd_data[START_BIT], 1'b0);
    // single mode stops at the descriptor end before the count runs out
    wr(OFS_CHAIN_BYTE_COUNT_LOW, 32'h10);
    wr(OFS_TRANSFER_CONTROL, CMD);
    acq_valid <= 1'b1;
    n0 = wr_cnt;
    wr(OFS_DMA_START, 32'h1);
    idle();
    chk(wr_cnt - n0, 2);
    chk(take_cnt, 6);
    rd(OFS_BYTES_REMAINING_LOW);
    chk(rd_data, 32'h8);
  endtask : auto_abort

  // reset for 8 cycles, then the scenarios
  initial
  begin
    s_req = '0;
    s_req.bready = 1'b1;
    s_req.rready = 1'b1;
    acq_valid = 1'b0;
    lag = 4'h0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    regs_check();
    write_run();
    chain_read();
    auto_abort();
    results();
  end
endmodule : sgdma_ctrl_tb
